// [hw/ssr_edge_detect.sv]
// rising edge detector for a group of trigger inputs
`timescale 1ns/1ps
module ssr_edge_detect
  import ssr_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  // ==========================================================
  // previous sample per input
  logic [WIDTH-1:0] prev_reg;  // level one cycle ago

  // remember last level; low after reset so a held high counts once
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  // one pulse per low-to-high change, falls ignored
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_rise
      assign rise[g] = level[g] & ~prev_reg[g];
    end
  endgenerate
endmodule // ssr_edge_detect

// [hw/ssr_pkg.sv]
// constants shared by the selectable shift register block
package ssr_pkg;
  // ==========================================================
  // storage layout
  localparam int unsigned SSR_BYTE_COUNT = 4;   // independent bytes
  localparam int unsigned SSR_BYTE_BITS  = 8;   // bits per byte
  localparam int unsigned SSR_IDX_W      = 2;   // byte index width
  localparam int unsigned SSR_BIT_W      = 3;   // bit select width
  // ==========================================================
  // apb register map, byte addresses
  localparam int unsigned SSR_ADDR_W     = 8;
  localparam logic [7:0]  SSR_CONFIG_OFF = 8'h00;  // byte index and output bit
  localparam logic [7:0]  SSR_STATUS_OFF = 8'h04;  // output and last direction
  localparam logic [7:0]  SSR_DATA_OFF   = 8'h08;  // all 32 storage bits
  // ==========================================================
  // field positions
  localparam int unsigned SSR_CFG_IDX_LSB = 0;     // byte index field
  localparam int unsigned SSR_CFG_BIT_LSB = 4;     // output bit field
  localparam int unsigned SSR_STS_OUT_BIT = 0;     // current output
  localparam int unsigned SSR_STS_DIR_BIT = 1;     // direction of last shift
  // ==========================================================
  // reset values
  localparam logic [1:0]  SSR_IDX_RESET  = 2'h0;   // byte 1
  localparam logic [2:0]  SSR_BIT_RESET  = 3'h0;   // bit position 1
  localparam logic [7:0]  SSR_BYTE_RESET = 8'h00;
  localparam logic [31:0] SSR_ZERO_WORD  = 32'h0000_0000;
endpackage

// [hw/ssr_shift_bank.sv]
// selectable shift register bank with apb configuration
//
// Contract
// - shift only on trigger rising edge
// - trigger falling edge changes nothing
// - shifted-in bit is sampled serial input
// - direction low shifts toward bit eight
// - direction high shifts toward bit one
// - clear rising edge zeroes selected byte
// - byte index one to four selects byte
// - output follows one selected bit
// - storage is four independent eight-bit bytes
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ssr_shift_bank
  import ssr_pkg::*;
#(
  parameter int unsigned BYTES = SSR_BYTE_COUNT
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  // function-block side
  input  wire logic                  serialIn,
  input  wire logic                  shiftTrigger,
  input  wire logic                  shiftDirection,
  input  wire logic                  clearTrigger,
  output logic                       bitOut,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [SSR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);
  // ==========================================================
  // declarations
  logic [SSR_BYTE_BITS-1:0] bank_reg [BYTES];   // storage bytes
  logic [SSR_BYTE_BITS-1:0] bank_next [BYTES];  // storage next values
  logic [31:0]              bankFlat;           // storage, byte 1 lowest
  logic [31:0]              bankNextFlat;       // next storage, flat
  logic [SSR_IDX_W-1:0]     byteSel_reg;        // selected byte
  logic [SSR_IDX_W-1:0]     byteSel_next;
  logic [SSR_BIT_W-1:0]     bitSel_reg;         // selected output bit
  logic [SSR_BIT_W-1:0]     bitSel_next;
  logic                     lastDir_reg;        // direction of last shift
  logic                     bitOut_reg;         // registered output
  logic [31:0]              prdata_reg;         // read data captured in setup
  logic                     pslverr_reg;        // unmapped address flag
  logic [1:0]               rise;               // edge pulses
  logic                     trigRise;           // trigger edge
  logic                     clrRise;            // clear edge
  logic                     cfgWrite;           // config write accepted
  logic                     setupPhase;         // apb setup cycle
  logic                     mapped;             // address decodes
  logic [31:0]              cfgWord;            // config register as read
  logic [31:0]              stsWord;            // status register as read

  // ==========================================================
  // edge detection of trigger and clear
  ssr_edge_detect #(
    .WIDTH (2)
  ) u_edges (
    .clk   (clk),
    .reset (reset),
    .level ({clearTrigger, shiftTrigger}),
    .rise  (rise)
  );
  assign trigRise = rise[0];
  assign clrRise  = rise[1];

  // ==========================================================
  // apb decode
  assign setupPhase = psel & ~penable;
  assign mapped     = (paddr == SSR_CONFIG_OFF) || (paddr == SSR_STATUS_OFF) || (paddr == SSR_DATA_OFF);
  assign cfgWrite   = psel & penable & pwrite & (paddr == SSR_CONFIG_OFF);
  assign pready     = psel & penable;  // zero wait states
  assign prdata     = prdata_reg;
  assign pslverr    = pslverr_reg & psel & penable;

  // config word as software reads it, unused bits zero
  always_comb begin
    cfgWord                               = SSR_ZERO_WORD;
    cfgWord[SSR_CFG_IDX_LSB +: SSR_IDX_W] = byteSel_reg;
    cfgWord[SSR_CFG_BIT_LSB +: SSR_BIT_W] = bitSel_reg;
  end

  // status word: current output and direction of the last shift
  always_comb begin
    stsWord                  = SSR_ZERO_WORD;
    stsWord[SSR_STS_OUT_BIT] = bitOut_reg;
    stsWord[SSR_STS_DIR_BIT] = lastDir_reg;
  end

  // configuration next values
  always_comb begin
    byteSel_next = byteSel_reg;
    bitSel_next  = bitSel_reg;
    if (cfgWrite) begin
      byteSel_next = pwdata[SSR_CFG_IDX_LSB +: SSR_IDX_W];
      bitSel_next  = pwdata[SSR_CFG_BIT_LSB +: SSR_BIT_W];
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      byteSel_reg <= SSR_IDX_RESET;
      bitSel_reg  <= SSR_BIT_RESET;
    end else begin
      byteSel_reg <= byteSel_next;
      bitSel_reg  <= bitSel_next;
    end
  end

  // reading in setup lets the access phase answer with no wait state
  // read data and error captured in the setup cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg  <= SSR_ZERO_WORD;
      pslverr_reg <= 1'b0;
    end else if (setupPhase) begin
      pslverr_reg <= ~mapped;
      prdata_reg  <= SSR_ZERO_WORD;
      if (!pwrite) begin
        case (paddr)
          SSR_CONFIG_OFF: begin
            prdata_reg <= cfgWord;
          end
          SSR_STATUS_OFF: begin
            prdata_reg <= stsWord;
          end
          SSR_DATA_OFF: begin
            prdata_reg <= bankFlat;
          end
          default: begin
            prdata_reg <= SSR_ZERO_WORD;  // unmapped reads zero
          end
        endcase
      end
    end
  end

  // ==========================================================
  // storage next values, one per byte
  genvar b;
  generate
    for (b = 0; b < BYTES; b++) begin : g_byte
      always_comb begin
        bank_next[b] = bank_reg[b];
        if (byteSel_reg == SSR_IDX_W'(b)) begin
          if (clrRise) begin
            bank_next[b] = SSR_BYTE_RESET;
          end else if (trigRise && !shiftDirection) begin
            bank_next[b] = {bank_reg[b][SSR_BYTE_BITS-2:0], serialIn};
          end else if (trigRise) begin
            bank_next[b] = {serialIn, bank_reg[b][SSR_BYTE_BITS-1:1]};
          end
        end
      end
      assign bankFlat[b*SSR_BYTE_BITS +: SSR_BYTE_BITS]     = bank_reg[b];
      assign bankNextFlat[b*SSR_BYTE_BITS +: SSR_BYTE_BITS] = bank_next[b];
      // storage byte register
      always_ff @(posedge clk) begin
        if (reset) begin
          bank_reg[b] <= SSR_BYTE_RESET;
        end else begin
          bank_reg[b] <= bank_next[b];
        end
      end
    end
  endgenerate

  // ==========================================================
  // direction of the last performed shift
  always_ff @(posedge clk) begin
    if (reset) begin
      lastDir_reg <= 1'b0;
    end else if (trigRise && !clrRise) begin
      lastDir_reg <= shiftDirection;
    end
  end

  // ==========================================================
  // output bit from the next storage and selection
  // next values used so the output never lags a shift or a config write
  always_ff @(posedge clk) begin
    if (reset) begin
      bitOut_reg <= 1'b0;
    end else begin
      bitOut_reg <= bankNextFlat[{byteSel_next, bitSel_next}];
    end
  end
  assign bitOut = bitOut_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] selByte;  // current selected byte
  assign selByte = bankFlat[{byteSel_reg, 3'h0} +: 8];

  // edge pulse follows the trigger history, skipped right after reset
  trig_rise_a: assert property (!$past(reset) |-> trigRise == (shiftTrigger && !$past(shiftTrigger)))
    else $error("trigger edge pulse wrong");
  // a held-high trigger gives one pulse only
  single_pulse_a: assert property (trigRise |=> !trigRise)
    else $error("trigger pulse longer than one cycle");
  // no edge, no change: falling edges and held levels leave storage alone
  no_fall_shift_a: assert property ((!trigRise && !clrRise) |=> $stable(bankFlat))
    else $error("storage changed without edge");
  // upward shift: sampled bit enters the low end
  sample_in_a: assert property ((trigRise && !clrRise && !shiftDirection && !cfgWrite)
      |=> selByte[0] == $past(serialIn))
    else $error("sampled bit not in bit one");
  shift_up_a: assert property ((trigRise && !clrRise && !shiftDirection && !cfgWrite)
      |=> selByte[7:1] == $past(selByte[6:0]))
    else $error("upward shift wrong");
  // downward shift: sampled bit enters the high end, low bit dropped
  shift_down_a: assert property ((trigRise && !clrRise && shiftDirection && !cfgWrite)
      |=> selByte == {$past(serialIn), $past(selByte[7:1])})
    else $error("downward shift wrong");
  // clear beats a trigger in the same cycle
  clear_wins_a: assert property ((clrRise && !cfgWrite) |=> selByte == 8'h00)
    else $error("clear did not zero byte");
  // a clear is no shift, so the recorded direction stays
  clear_dir_a: assert property (clrRise |=> $stable(lastDir_reg))
    else $error("clear changed last direction");
  // direction recorded only by a performed shift
  last_dir_a: assert property ((trigRise && !clrRise) |=> lastDir_reg == $past(shiftDirection))
    else $error("last direction not recorded");
  // first byte selected: upper bytes untouched
  other_bytes_a: assert property ((byteSel_reg == 2'h0) |=> bankFlat[31:8] == $past(bankFlat[31:8]))
    else $error("unselected byte changed");
  // output equals the selected bit at every edge
  output_sel_a: assert property (bitOut == bankFlat[{byteSel_reg, bitSel_reg}])
    else $error("output not selected bit");
  // output only moves with storage or selection
  out_steady_a: assert property ((!trigRise && !clrRise && !cfgWrite) |=> $stable(bitOut))
    else $error("output moved without cause");

  // each unselected byte keeps its value, whatever happens to the selected one
  generate
    for (b = 0; b < BYTES; b++) begin : g_keep
      keep_byte_a: assert property ((byteSel_reg != SSR_IDX_W'(b)) |=> $stable(bank_reg[b]))
        else $error("byte changed while not selected");
    end
  endgenerate

  // ==========================================================
  // assertions on the register bus
  // a config write lands at the access edge
  cfg_write_a: assert property (cfgWrite |=> byteSel_reg == $past(pwdata[SSR_CFG_IDX_LSB +: SSR_IDX_W])
      && bitSel_reg == $past(pwdata[SSR_CFG_BIT_LSB +: SSR_BIT_W]))
    else $error("config write lost");
  // selection only changes by a config write
  cfg_hold_a: assert property (!cfgWrite |=> $stable(byteSel_reg) && $stable(bitSel_reg))
    else $error("selection changed without write");
  // error flag only in the access phase of an unmapped address
  err_unmapped_a: assert property ((setupPhase && !mapped) |=> pslverr == (psel && penable))
    else $error("missing error on unmapped address");
  err_mapped_a: assert property ((setupPhase && mapped) |=> !pslverr)
    else $error("error on mapped address");
  // slave says nothing while not selected
  no_idle_ready_a: assert property (!psel |-> !pready && !pslverr)
    else $error("answer outside a transfer");
  // read word captured in setup and held until the next setup
  rdata_stands_a: assert property (!setupPhase |=> $stable(prdata))
    else $error("read data moved outside setup");
  rdata_cfg_a: assert property ((setupPhase && !pwrite && paddr == SSR_CONFIG_OFF)
      |=> prdata[SSR_CFG_IDX_LSB +: SSR_IDX_W] == $past(byteSel_reg) && prdata[SSR_CFG_BIT_LSB +: SSR_BIT_W] == $past(bitSel_reg))
    else $error("config read wrong");
  rdata_sts_a: assert property ((setupPhase && !pwrite && paddr == SSR_STATUS_OFF)
      |=> prdata[SSR_STS_OUT_BIT] == $past(bitOut) && prdata[SSR_STS_DIR_BIT] == $past(lastDir_reg))
    else $error("status read wrong");
  rdata_write_a: assert property ((setupPhase && pwrite) |=> prdata == SSR_ZERO_WORD)
    else $error("read data during write not zero");
  rdata_bank_a: assert property ((setupPhase && !pwrite && paddr == SSR_DATA_OFF) |=> prdata == $past(bankFlat))
    else $error("storage read wrong");
  unmapped_zero_a: assert property ((setupPhase && !mapped) |=> prdata == SSR_ZERO_WORD)
    else $error("unmapped read not zero");

  // ==========================================================
  // covers of the main scenarios
  // two upward shifts one after the other
  up_shift_c: cover property ((trigRise && !shiftDirection) ##[2:60] (trigRise && !shiftDirection));
  // downward shift
  down_shift_c: cover property (trigRise && shiftDirection);
  // clear and trigger together
  clear_trig_c: cover property (trigRise && clrRise);
  // last byte selected by software
  cfg_write_c: cover property (cfgWrite && byteSel_next == 2'h3);
  // access to an unmapped address
  unmapped_c: cover property (setupPhase && !mapped);
endmodule // ssr_shift_bank

// [tb/ssr_fb_model.sv]
// stand-in for the function blocks that feed the shift register bank
`timescale 1ns/1ps
module ssr_fb_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic cmdShift,               // hold shift trigger high
  input  wire logic cmdClear,               // hold clear trigger high
  input  wire logic cmdBit,                 // bit offered for the shift
  input  wire logic cmdDir,                 // direction for the shift
  output logic      serialIn       = 1'b0,
  output logic      shiftTrigger   = 1'b0,
  output logic      shiftDirection = 1'b0,
  output logic      clearTrigger   = 1'b0
);
  // ==========================================================
  // triggers follow the commands one edge later
  always @(posedge clk) begin
    if (reset) begin
      shiftTrigger <= 1'b0;
      clearTrigger <= 1'b0;
    end else begin
      shiftTrigger <= cmdShift;
      clearTrigger <= cmdClear;
    end
  end
  // data and direction valid only while triggered, otherwise toggling
  always @(posedge clk) begin
    serialIn       <= cmdShift ? cmdBit : ~serialIn;
    shiftDirection <= cmdShift ? cmdDir : ~shiftDirection;
  end
endmodule // ssr_fb_model

// [tb/tb_ssr_shift_bank.sv]
// random and corner-case bench for the shift register bank
`timescale 1ns/1ps
module tb_ssr_shift_bank;
  import ssr_pkg::*;
  logic        clk = 1'b0, reset = 1'b1;           // clock and sync reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;                       // apb address
  logic [31:0] pwdata = 32'h0, prdata, rd;          // apb data
  logic        pready, pslverr, err, bitOut;
  logic        serialIn, shiftTrigger, shiftDirection, clearTrigger;
  logic        cmdShift = 1'b0, cmdClear = 1'b0, cmdBit = 1'b0, cmdDir = 1'b0;
  logic [31:0] model = 32'h0;                       // expected storage
  logic [1:0]  idx = 2'h0;                          // expected byte index
  logic [2:0]  sel = 3'h0;                          // expected output bit
  logic        lastDir = 1'b0;                      // expected last direction
  logic [31:0] r;                                   // random draw
  int          n_mismatch = 0, tests_run = 0, seed = 32'h681b786e;
  ssr_shift_bank dut (.clk(clk), .reset(reset), .serialIn(serialIn), .shiftTrigger(shiftTrigger),
    .shiftDirection(shiftDirection), .clearTrigger(clearTrigger), .bitOut(bitOut), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ssr_fb_model fb_model (.clk(clk), .reset(reset), .cmdShift(cmdShift), .cmdClear(cmdClear),
    .cmdBit(cmdBit), .cmdDir(cmdDir), .serialIn(serialIn), .shiftTrigger(shiftTrigger),
    .shiftDirection(shiftDirection), .clearTrigger(clearTrigger));
  // ==========================================================
  // clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // expected byte after one shift
  function automatic logic [7:0] shifted(input logic [7:0] b, input logic d, input logic i);
    return d ? {i, b[7:1]} : {b[6:0], i};
  endfunction
  // verdict and end of run
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, waiting for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // new byte index and output bit
  task automatic cfg(input logic [1:0] i, input logic [2:0] s);
    idx = i;
    sel = s;
    apb(1'b1, SSR_CONFIG_OFF, {25'h1FF_FFFF, s, 2'h3, i});
    apb(1'b0, SSR_CONFIG_OFF, 32'h0);
    check(rd, {25'h0, s, 2'h0, i});
  endtask
  // one function-block event with the trigger held h cycles
  task automatic fb(input logic s, input logic c, input logic b, input logic d, input int h);
    @(posedge clk);
    cmdShift <= s;
    cmdClear <= c;
    cmdBit   <= b;
    cmdDir   <= d;
    repeat (h) @(posedge clk);
    cmdShift <= 1'b0;
    cmdClear <= 1'b0;
    repeat (3) @(posedge clk);
    if (c) model[idx*8 +: 8] = 8'h00;
    else if (s) model[idx*8 +: 8] = shifted(model[idx*8 +: 8], d, b);
    if (s && !c) lastDir = d;
    check({31'h0, bitOut}, {31'h0, model[{idx, sel}]});
    apb(1'b0, SSR_DATA_OFF, 32'h0);
    check(rd, model);
    apb(1'b0, SSR_STATUS_OFF, 32'h0);
    check(rd, {30'h0, lastDir, model[{idx, sel}]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, SSR_CONFIG_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001);
    fb(1'b1, 1'b0, 1'b1, 1'b0, 5);
    cfg(2'h3, 3'h7);
    fb(1'b1, 1'b0, 1'b1, 1'b1, 1);
    fb(1'b1, 1'b1, 1'b1, 1'b1, 1);
    fb(1'b0, 1'b1, 1'b0, 1'b0, 2);
    fb(1'b0, 1'b0, 1'b1, 1'b1, 2);
    repeat (300) begin
      r = $random(seed);
      if (r[3:0] == 4'h0) cfg(r[5:4], r[8:6]);
      fb(r[11:9] != 3'h1, r[11:9] <= 3'h1, r[12], r[13], 1 + r[15:14]);
    end
    // reset again in mid-run: everything back to its reset value
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    model = 32'h0;
    idx = 2'h0;
    sel = 3'h0;
    lastDir = 1'b0;
    apb(1'b0, SSR_CONFIG_OFF, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, SSR_DATA_OFF, 32'h0);
    check(rd, model);
    fb(1'b1, 1'b0, 1'b1, 1'b0, 1);
    give_verdict();
  end
endmodule // tb_ssr_shift_bank
